/* File: core/fscd_map.svh */
`ifndef FSCD_MAP_SVH
`define FSCD_MAP_SVH
// Setting opcodes
`define FSCD_OP_SET_WEL 8'h06
`define FSCD_OP_CLR_WEL 8'h04
`define FSCD_OP_RD_ST 8'h05
`define FSCD_OP_RD_CFG 8'h15
`define FSCD_OP_WR_SC 8'h01
`define FSCD_OP_RD_EXT 8'hc8
`define FSCD_OP_WR_EXT 8'hc5
`define FSCD_OP_EN_QUAD 8'h35
`define FSCD_OP_EX_QUAD 8'hf5
`define FSCD_OP_EN_WIDE 8'hb7
`define FSCD_OP_EX_WIDE 8'he9
`define FSCD_OP_SUSPEND 8'hb0
`define FSCD_OP_RESUME 8'h30
`define FSCD_OP_SLEEP 8'hb9
`define FSCD_OP_WAKE 8'hab
`define FSCD_OP_BURST 8'hc0
`define FSCD_OP_RD_BOOT 8'h16
`define FSCD_OP_WR_BOOT 8'h17
`define FSCD_OP_ER_BOOT 8'h18
// Field positions
`define FSCD_ST_WEL_BIT 1
`define FSCD_CFG_WIDE_BIT 5
`define FSCD_ST_WR_MASK 8'hfc
`define FSCD_CFG_WR_MASK 8'hdf
// Reset values
`define FSCD_ST_RST 8'h00
`define FSCD_CFG_RST 8'h00
`define FSCD_EXT_RST 8'h00
`define FSCD_BURST_RST 8'h00
`define FSCD_BOOT_ERASED 32'hffffffff
// Byte lengths
`define FSCD_WR_BOOT_LEN 4
`define FSCD_RD_MAX_LEN 4
// Timing
`define FSCD_CLK_PERIOD_NS 8
`define FSCD_SCLK_PERIOD_NS 64
`define FSCD_SCLK_HALF (`FSCD_SCLK_PERIOD_NS / (2 * `FSCD_CLK_PERIOD_NS))
`endif

/* File: core/fscd_pkg.sv */
`include "fscd_map.svh"
package fscd_pkg;
	typedef logic [7:0] fscd_byte_t;
	typedef logic [3:0] fscd_nib_t;
	typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_TAIL} fscd_hst_t;

	// Commands that answer with data
	function automatic logic fscd_is_read(input fscd_byte_t op);
		return (op == `FSCD_OP_RD_ST) || (op == `FSCD_OP_RD_CFG) ||
			(op == `FSCD_OP_RD_EXT) || (op == `FSCD_OP_RD_BOOT);
	endfunction
endpackage

/* File: core/fscd_if.sv */
`timescale 1ns/1ps
interface fscd_if;
	logic sclk;
	logic cs_n;
	logic [3:0] h_sio_o;
	logic [3:0] h_sio_oe;
	logic [3:0] d_sio_o;
	logic [3:0] d_sio_oe;
	logic [3:0] sio;

	// Wire level per line; undriven lines float high through a pull-up
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (h_sio_oe[i])
				sio[i] = h_sio_o[i];
			else if (d_sio_oe[i])
				sio[i] = d_sio_o[i];
			else
				sio[i] = 1'b1;
		end
	end

	modport dev (input sclk, input cs_n, input sio, output d_sio_o, output d_sio_oe);
	modport host (output sclk, output cs_n, input sio, output h_sio_o, output h_sio_oe);
endinterface

/* File: core/fscd_dev.sv */
`timescale 1ns/1ps
`include "fscd_map.svh"
module fscd_dev (
	// Link
	fscd_if.dev lnk,
	// Hardware reset pin
	input wire logic i_rst,
	// Setting state
	output fscd_pkg::fscd_byte_t o_status,
	output fscd_pkg::fscd_byte_t o_config,
	output fscd_pkg::fscd_byte_t o_ext_addr,
	output fscd_pkg::fscd_byte_t o_burst_len,
	output logic [31:0] o_boot_reg,
	output logic o_quad,
	output logic o_wide,
	output logic o_sleep,
	output logic o_suspend
);
	import fscd_pkg::*;

	logic frm_clr;
	logic first_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] byte_cnt_reg;
	fscd_byte_t sh_reg;
	fscd_byte_t op_reg;
	fscd_byte_t dat_reg [4];
	logic frm_tog_reg;
	logic seen_tog_reg;
	logic [2:0] cnt_bit;
	logic [2:0] cnt_byte;
	fscd_byte_t in_byte;
	logic byte_done;
	logic [2:0] n_dat;
	logic whole;
	logic rd_ok;
	fscd_byte_t rd_val;
	fscd_nib_t sio_o_reg;
	fscd_nib_t sio_oe_reg;

	// Answer byte for a read command; boot register wraps every four bytes
	function automatic fscd_byte_t rd_byte(input fscd_byte_t op, input logic [1:0] idx);
		case (op)
			`FSCD_OP_RD_ST: return o_status;
			`FSCD_OP_RD_CFG: return o_config;
			`FSCD_OP_RD_EXT: return o_ext_addr;
			`FSCD_OP_RD_BOOT: return o_boot_reg[{idx, 3'b000} +: 8];
			default: return 8'h00;
		endcase
	endfunction

	// Frame state is dropped whenever chip select is high
	assign frm_clr = i_rst | lnk.cs_n;

	// First edge of a frame; counters restart there, not at deselect,
	// so the finished frame stays readable for the commit at deselect
	always_ff @(posedge lnk.sclk or posedge frm_clr) begin
		if (frm_clr)
			first_reg <= 1'b1;
		else
			first_reg <= 1'b0;
	end

	assign cnt_bit = first_reg ? 3'h0 : bit_cnt_reg;
	assign cnt_byte = first_reg ? 3'h0 : byte_cnt_reg;
	assign in_byte = o_quad ? {sh_reg[3:0], lnk.sio} : {sh_reg[6:0], lnk.sio[0]};
	assign byte_done = o_quad ? (cnt_bit == 3'h1) : (cnt_bit == 3'h7);

	// Input shifter and byte capture on the rising link clock
	always_ff @(posedge lnk.sclk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			op_reg <= 8'h00;
			frm_tog_reg <= 1'b0;
			for (int i = 0; i < 4; i++)
				dat_reg[i] <= 8'h00;
		end else begin
			sh_reg <= in_byte;
			if (first_reg)
				frm_tog_reg <= ~frm_tog_reg;
			if (byte_done) begin
				bit_cnt_reg <= 3'h0;
				if (cnt_byte == 3'h0)
					op_reg <= in_byte;
				else if (cnt_byte <= 3'h4)
					dat_reg[cnt_byte[1:0] - 2'h1] <= in_byte;
				// Saturates; long reads keep clocking without wrapping the count
				if (cnt_byte != 3'h7)
					byte_cnt_reg <= cnt_byte + 3'h1;
			end else begin
				bit_cnt_reg <= cnt_bit + 3'h1;
				byte_cnt_reg <= cnt_byte;
			end
		end
	end

	assign whole = (bit_cnt_reg == 3'h0) && (byte_cnt_reg != 3'h0) &&
		(frm_tog_reg != seen_tog_reg);
	assign n_dat = byte_cnt_reg - 3'h1;

	// Commit on deselect; the link clock is stopped, so frame data is steady
	always_ff @(posedge lnk.cs_n or posedge i_rst) begin
		if (i_rst) begin
			o_status <= `FSCD_ST_RST;
			o_config <= `FSCD_CFG_RST;
			o_ext_addr <= `FSCD_EXT_RST;
			o_burst_len <= `FSCD_BURST_RST;
			o_boot_reg <= `FSCD_BOOT_ERASED;
			o_quad <= 1'b0;
			o_wide <= 1'b0;
			o_sleep <= 1'b0;
			o_suspend <= 1'b0;
			seen_tog_reg <= 1'b0;
		end else begin
			seen_tog_reg <= frm_tog_reg;
			if (whole && (!o_sleep || op_reg == `FSCD_OP_WAKE)) begin
				case (op_reg)
					`FSCD_OP_SET_WEL: if (n_dat == 3'h0)
						o_status[`FSCD_ST_WEL_BIT] <= 1'b1;
					`FSCD_OP_CLR_WEL: if (n_dat == 3'h0)
						o_status[`FSCD_ST_WEL_BIT] <= 1'b0;
					`FSCD_OP_WR_SC: begin
						if (o_status[`FSCD_ST_WEL_BIT] &&
								(n_dat == 3'h1 || n_dat == 3'h2)) begin
							o_status <= (dat_reg[0] & `FSCD_ST_WR_MASK) |
								(o_status & ~`FSCD_ST_WR_MASK & 8'hfd);
							if (n_dat == 3'h2)
								o_config <= (dat_reg[1] & `FSCD_CFG_WR_MASK) |
									(o_config & ~`FSCD_CFG_WR_MASK);
						end
					end
					`FSCD_OP_WR_EXT: if (n_dat == 3'h1)
						o_ext_addr <= dat_reg[0];
					`FSCD_OP_EN_QUAD: if (n_dat == 3'h0 && !o_quad)
						o_quad <= 1'b1;
					`FSCD_OP_EX_QUAD: if (n_dat == 3'h0 && o_quad)
						o_quad <= 1'b0;
					`FSCD_OP_EN_WIDE: if (n_dat == 3'h0) begin
						o_wide <= 1'b1;
						o_config[`FSCD_CFG_WIDE_BIT] <= 1'b1;
					end
					`FSCD_OP_EX_WIDE: if (n_dat == 3'h0) begin
						o_wide <= 1'b0;
						o_config[`FSCD_CFG_WIDE_BIT] <= 1'b0;
					end
					`FSCD_OP_SUSPEND: if (n_dat == 3'h0)
						o_suspend <= 1'b1;
					`FSCD_OP_RESUME: if (n_dat == 3'h0)
						o_suspend <= 1'b0;
					`FSCD_OP_SLEEP: if (n_dat == 3'h0)
						o_sleep <= 1'b1;
					`FSCD_OP_WAKE: o_sleep <= 1'b0;
					`FSCD_OP_BURST: if (n_dat == 3'h1)
						o_burst_len <= dat_reg[0];
					`FSCD_OP_WR_BOOT: begin
						if (!o_quad && o_status[`FSCD_ST_WEL_BIT] &&
								n_dat == 3'(`FSCD_WR_BOOT_LEN)) begin
							o_boot_reg <= {dat_reg[3], dat_reg[2], dat_reg[1], dat_reg[0]};
							o_status[`FSCD_ST_WEL_BIT] <= 1'b0;
						end
					end
					`FSCD_OP_ER_BOOT: begin
						if (!o_quad && o_status[`FSCD_ST_WEL_BIT] && n_dat == 3'h0) begin
							o_boot_reg <= `FSCD_BOOT_ERASED;
							o_status[`FSCD_ST_WEL_BIT] <= 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign rd_ok = !first_reg && (byte_cnt_reg != 3'h0) && !o_sleep &&
		fscd_is_read(op_reg) && !(o_quad && op_reg == `FSCD_OP_RD_BOOT);
	assign rd_val = rd_byte(op_reg, n_dat[1:0]);

	// Output launched on the falling link clock, MSB first
	always_ff @(negedge lnk.sclk or posedge frm_clr) begin
		if (frm_clr) begin
			sio_o_reg <= 4'h0;
			sio_oe_reg <= 4'h0;
		end else if (rd_ok) begin
			if (o_quad) begin
				sio_o_reg <= (bit_cnt_reg == 3'h0) ? rd_val[7:4] : rd_val[3:0];
				sio_oe_reg <= 4'hf;
			end else begin
				sio_o_reg <= {2'b00, rd_val[3'h7 - bit_cnt_reg], 1'b0};
				sio_oe_reg <= 4'h2;
			end
		end else begin
			sio_o_reg <= 4'h0;
			sio_oe_reg <= 4'h0;
		end
	end

	assign lnk.d_sio_o = sio_o_reg;
	assign lnk.d_sio_oe = sio_oe_reg;
endmodule // fscd_dev

/* File: core/fscd_host.sv */
`timescale 1ns/1ps
`include "fscd_map.svh"
module fscd_host #(
	parameter int HALF = `FSCD_SCLK_HALF
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link
	fscd_if.host lnk,
	// Command request
	input wire logic i_start,
	input wire fscd_pkg::fscd_byte_t i_opcode,
	input wire logic [2:0] i_len,
	input wire logic [31:0] i_wdata,
	// Command answer
	output logic o_busy,
	output logic o_done,
	output logic o_refused,
	output logic [31:0] o_rdata,
	output logic o_quad,
	output logic o_wel,
	output logic o_sleep
);
	import fscd_pkg::*;

	fscd_hst_t st_reg;
	logic [7:0] div_reg;
	logic sclk_reg;
	logic cs_n_reg;
	logic [39:0] tx_reg;
	logic [39:0] tx_sh;
	logic [5:0] sent_reg;
	logic [5:0] sent_next;
	logic [5:0] nbits_reg;
	fscd_byte_t rx_reg;
	fscd_byte_t rx_next;
	fscd_byte_t op_reg;
	logic rd_reg;
	fscd_nib_t s1_reg;
	fscd_nib_t s2_reg;
	fscd_nib_t sio_o_reg;
	fscd_nib_t sio_oe_reg;
	logic tick;

	// Legality of a request against the mode the host believes in
	function automatic logic cmd_ok(input fscd_byte_t op, input logic [2:0] n,
			input logic q, input logic w, input logic s);
		logic rd_len;
		rd_len = (n != 3'h0) && (n <= 3'(`FSCD_RD_MAX_LEN));
		if (s && op != `FSCD_OP_WAKE)
			return 1'b0;
		case (op)
			`FSCD_OP_SET_WEL, `FSCD_OP_CLR_WEL, `FSCD_OP_EN_WIDE, `FSCD_OP_EX_WIDE,
			`FSCD_OP_SUSPEND, `FSCD_OP_RESUME, `FSCD_OP_SLEEP, `FSCD_OP_WAKE:
				return n == 3'h0;
			`FSCD_OP_RD_ST, `FSCD_OP_RD_CFG, `FSCD_OP_RD_EXT: return rd_len;
			`FSCD_OP_WR_SC: return w && (n == 3'h1 || n == 3'h2);
			`FSCD_OP_WR_EXT, `FSCD_OP_BURST: return n == 3'h1;
			`FSCD_OP_EN_QUAD: return !q && n == 3'h0;
			`FSCD_OP_EX_QUAD: return q && n == 3'h0;
			`FSCD_OP_RD_BOOT: return !q && rd_len;
			`FSCD_OP_WR_BOOT: return !q && w && n == 3'(`FSCD_WR_BOOT_LEN);
			`FSCD_OP_ER_BOOT: return !q && w && n == 3'h0;
			default: return 1'b0;
		endcase
	endfunction

	// Data lines come from the other party's clock; two stages first
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_reg <= 4'hf;
			s2_reg <= 4'hf;
		end else begin
			s1_reg <= lnk.sio;
			s2_reg <= s1_reg;
		end
	end

	assign tick = div_reg == 8'(HALF - 1);
	assign tx_sh = o_quad ? {tx_reg[35:0], 4'h0} : {tx_reg[38:0], 1'b0};
	assign sent_next = sent_reg + (o_quad ? 6'h4 : 6'h1);
	assign rx_next = o_quad ? {rx_reg[3:0], s2_reg} : {rx_reg[6:0], s2_reg[1]};

	// Frame sequencer; the link clock is a divided copy of i_clk
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= HS_IDLE;
			div_reg <= 8'h00;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			tx_reg <= 40'h0;
			sent_reg <= 6'h0;
			nbits_reg <= 6'h0;
			rx_reg <= 8'h00;
			op_reg <= 8'h00;
			rd_reg <= 1'b0;
			sio_o_reg <= 4'h0;
			sio_oe_reg <= 4'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_refused <= 1'b0;
			o_rdata <= 32'h0;
			o_quad <= 1'b0;
			o_wel <= 1'b0;
			o_sleep <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_refused <= 1'b0;
			div_reg <= tick ? 8'h00 : div_reg + 8'h1;
			unique case (st_reg)
				HS_IDLE: begin
					div_reg <= 8'h00;
					if (i_start) begin
						if (cmd_ok(i_opcode, i_len, o_quad, o_wel, o_sleep)) begin
							st_reg <= HS_RUN;
							o_busy <= 1'b1;
							cs_n_reg <= 1'b0;
							op_reg <= i_opcode;
							rd_reg <= fscd_is_read(i_opcode);
							tx_reg <= {i_opcode, i_wdata[7:0], i_wdata[15:8],
								i_wdata[23:16], i_wdata[31:24]};
							sent_reg <= 6'h0;
							nbits_reg <= {i_len, 3'b000} + 6'h8;
							o_rdata <= 32'h0;
							// Opcode on one or four lines
							sio_o_reg <= o_quad ? i_opcode[7:4] : {3'b000, i_opcode[7]};
							sio_oe_reg <= o_quad ? 4'hf : 4'h1;
						end else begin
							o_refused <= 1'b1;
						end
					end
				end
				HS_RUN: begin
					if (tick && !sclk_reg) begin
						// Rising edge: device samples, host samples read data
						sclk_reg <= 1'b1;
						sent_reg <= sent_next;
						if (rd_reg && sent_reg >= 6'h8) begin
							rx_reg <= rx_next;
							if (sent_next[2:0] == 3'h0)
								o_rdata[{sent_reg[4:3] - 2'h1, 3'b000} +: 8] <= rx_next;
						end
					end else if (tick) begin
						sclk_reg <= 1'b0;
						if (sent_reg == nbits_reg) begin
							// Deselect only on a byte boundary
							cs_n_reg <= 1'b1;
							sio_oe_reg <= 4'h0;
							st_reg <= HS_TAIL;
						end else begin
							tx_reg <= tx_sh;
							sio_o_reg <= o_quad ? tx_sh[39:36] : {3'b000, tx_sh[39]};
							// Turn the lines round once the opcode is out
							if (rd_reg && sent_reg >= 6'h8)
								sio_oe_reg <= 4'h0;
						end
					end
				end
				HS_TAIL: begin
					// Deselect time of one half period before the next frame
					if (tick) begin
						st_reg <= HS_IDLE;
						o_busy <= 1'b0;
						o_done <= 1'b1;
						case (op_reg)
							`FSCD_OP_SET_WEL: o_wel <= 1'b1;
							`FSCD_OP_CLR_WEL, `FSCD_OP_WR_SC, `FSCD_OP_WR_BOOT,
							`FSCD_OP_ER_BOOT: o_wel <= 1'b0;
							`FSCD_OP_EN_QUAD: o_quad <= 1'b1;
							`FSCD_OP_EX_QUAD: o_quad <= 1'b0;
							`FSCD_OP_SLEEP: o_sleep <= 1'b1;
							`FSCD_OP_WAKE: o_sleep <= 1'b0;
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	assign lnk.sclk = sclk_reg;
	assign lnk.cs_n = cs_n_reg;
	assign lnk.h_sio_o = sio_o_reg;
	assign lnk.h_sio_oe = sio_oe_reg;
endmodule // fscd_host

/* File: sim/fscd_checker.sv */
`timescale 1ns/1ps
module fscd_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] h_sio_oe,
	input wire logic [3:0] d_sio_oe
);
	logic sclk_prev_reg;
	logic [7:0] rise_cnt_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Link clock rises per frame, cleared while deselected
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_prev_reg <= 1'b0;
			rise_cnt_reg <= 8'h00;
		end else begin
			sclk_prev_reg <= sclk;
			if (cs_n)
				rise_cnt_reg <= 8'h00;
			else if (sclk && !sclk_prev_reg)
				rise_cnt_reg <= rise_cnt_reg + 8'h01;
		end
	end

	a_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("link clock high while deselected");
	a_lead_in: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
		else $error("first link clock rise mistimed");
	a_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	a_sclk_low: assert property ($fell(sclk) && !cs_n |-> !sclk [*4] ##1 sclk)
		else $error("link clock low phase wrong");
	a_host_lanes: assert property (h_sio_oe inside {4'h0, 4'h1, 4'hf})
		else $error("host drives wrong lanes");
	a_dev_lanes: assert property (d_sio_oe inside {4'h0, 4'h2, 4'hf})
		else $error("device drives wrong lanes");
	a_no_fight: assert property ((h_sio_oe & d_sio_oe) == 4'h0)
		else $error("both ends drive one lane");
	a_dev_quiet: assert property (cs_n && $past(cs_n) |-> d_sio_oe == 4'h0)
		else $error("device drives while deselected");
	a_gap_len: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("deselect gap too short");
	a_whole_bytes: assert property ($rose(cs_n) |-> !rise_cnt_reg[0] && rise_cnt_reg != 8'h00)
		else $error("frame ends on partial nibble pair");
endmodule // fscd_checker

/* File: sim/flash_setting_command_decoder_tb.sv */
`timescale 1ns/1ps
module flash_setting_command_decoder_tb;
	import fscd_pkg::*;
	logic i_clk, i_rst, i_start, done, refd, hq, dq, wide, slp, susp;
	logic busy, hw, hs;
	fscd_byte_t i_opcode, st, cfg, ext, bl;
	logic [2:0] i_len;
	logic [31:0] i_wdata, rdata, boot;
	int miscompares, comparisons;

	fscd_if i_fscd_if ();
	fscd_host i_fscd_host (.i_clk(i_clk), .i_rst(i_rst), .lnk(i_fscd_if.host),
		.i_start(i_start), .i_opcode(i_opcode), .i_len(i_len), .i_wdata(i_wdata),
		.o_busy(busy), .o_done(done), .o_refused(refd), .o_rdata(rdata), .o_quad(hq),
		.o_wel(hw), .o_sleep(hs));
	fscd_dev i_fscd_dev (.lnk(i_fscd_if.dev), .i_rst(i_rst), .o_status(st), .o_config(cfg),
		.o_ext_addr(ext), .o_burst_len(bl), .o_boot_reg(boot), .o_quad(dq), .o_wide(wide),
		.o_sleep(slp), .o_suspend(susp));
	fscd_checker i_fscd_checker (.i_clk(i_clk), .i_rst(i_rst), .sclk(i_fscd_if.sclk),
		.cs_n(i_fscd_if.cs_n), .h_sio_oe(i_fscd_if.h_sio_oe), .d_sio_oe(i_fscd_if.d_sio_oe));

	// System clock, 8 ns
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Verdict and end of run
	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One host request; entered and left at a clock edge
	task automatic run(input fscd_byte_t op, input int n, input int wd, input int rf);
		int k;
		i_opcode <= op;
		i_len <= n[2:0];
		i_wdata <= wd;
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start <= 1'b0;
		k = 0;
		// The refusal pulse stands only until the next edge, so look before waiting
		#1;
		chk("busy", (rf == 0) ? 32'h1 : 32'h0, {31'h0, busy});
		while (done !== 1'b1 && refd !== 1'b1 && k < 1000) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		if (k >= 1000) begin
			miscompares++;
			test_done();
		end
		chk("refused", rf, {31'h0, refd});
		@(posedge i_clk);
	endtask

	initial begin
		i_rst = 1'b1;
		i_start = 1'b0;
		i_opcode = 8'h00;
		i_len = 3'h0;
		i_wdata = 32'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk("status", 32'h0, {24'h0, st});
		chk("boot", 32'hffffffff, boot);
		chk("flags", 32'h0, {28'h0, dq, wide, slp, susp});
		$display("end of reset test");
		// Latch, status and configuration
		run(8'h06, 0, 32'h0, 0);
		chk("latch", 32'h2, {24'h0, st});
		chk("host latch", 32'h1, {31'h0, hw});
		run(8'h04, 0, 32'h0, 0);
		chk("latch", 32'h0, {24'h0, st});
		run(8'h01, 1, 32'ha4, 1);
		run(8'h06, 0, 32'h0, 0);
		run(8'h01, 2, 32'h8c5c, 0);
		chk("status", 32'h5c, {24'h0, st});
		chk("config", 32'h8c, {24'h0, cfg});
		run(8'h05, 2, 32'h0, 0);
		chk("rd status", 32'h5c5c, rdata);
		$display("end of status test");
		// Extended address, wide flag, suspend, burst
		run(8'hc5, 2, 32'h3a3a, 1);
		run(8'hc5, 1, 32'h3a, 0);
		chk("ext", 32'h3a, {24'h0, ext});
		run(8'hc8, 4, 32'h0, 0);
		chk("rd ext", 32'h3a3a3a3a, rdata);
		run(8'hb7, 0, 32'h0, 0);
		chk("wide", 32'h1, {31'h0, wide});
		run(8'h15, 1, 32'h0, 0);
		chk("rd config", 32'hac, rdata);
		run(8'he9, 0, 32'h0, 0);
		chk("wide", 32'h0, {31'h0, wide});
		run(8'hb0, 0, 32'h0, 0);
		chk("suspend", 32'h1, {31'h0, susp});
		run(8'h30, 0, 32'h0, 0);
		chk("suspend", 32'h0, {31'h0, susp});
		run(8'hc0, 1, 32'h07, 0);
		chk("burst", 32'h07, {24'h0, bl});
		$display("end of setting test");
		// Boot register
		run(8'h17, 4, 32'h11223344, 1);
		run(8'h06, 0, 32'h0, 0);
		run(8'h17, 4, 32'h11223344, 0);
		chk("boot", 32'h11223344, boot);
		run(8'h16, 4, 32'h0, 0);
		chk("rd boot", 32'h11223344, rdata);
		run(8'h06, 0, 32'h0, 0);
		run(8'h18, 0, 32'h0, 0);
		chk("boot", 32'hffffffff, boot);
		$display("end of boot test");
		// Quad command mode
		run(8'hf5, 0, 32'h0, 1);
		run(8'h35, 0, 32'h0, 0);
		chk("quad", 32'h3, {30'h0, dq, hq});
		run(8'h35, 0, 32'h0, 1);
		run(8'h16, 1, 32'h0, 1);
		run(8'h06, 0, 32'h0, 0);
		run(8'h05, 1, 32'h0, 0);
		chk("rd status", 32'h5e, rdata);
		run(8'hc5, 1, 32'h5a, 0);
		chk("ext", 32'h5a, {24'h0, ext});
		run(8'h04, 0, 32'h0, 0);
		chk("latch", 32'h5c, {24'h0, st});
		run(8'hf5, 0, 32'h0, 0);
		chk("quad", 32'h0, {30'h0, dq, hq});
		$display("end of quad test");
		// Sleep, requests the host refuses, hardware reset
		run(8'hb9, 0, 32'h0, 0);
		chk("sleep", 32'h3, {30'h0, slp, hs});
		run(8'h06, 0, 32'h0, 1);
		run(8'hab, 0, 32'h0, 0);
		chk("sleep", 32'h0, {31'h0, slp});
		run(8'h06, 1, 32'h0, 1);
		run(8'h9f, 0, 32'h0, 1);
		run(8'h06, 0, 32'h0, 0);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk("status", 32'h0, {24'h0, st});
		chk("host latch", 32'h0, {31'h0, hw});
		$display("end of sleep and reset test");
		test_done();
	end
endmodule // flash_setting_command_decoder_tb
